// ---- bench/cdr_cfg_regs_checker.sv ----
// Checker for the configuration register bank, bound to its top ports.
// Assumes one clock domain and the strobe port of the register decoder.
`timescale 1ns/1ps
module cdr_cfg_regs_checker
   import cdr_cfg_pkg::*;
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic rate_above_threshold_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic pd_rising_en_o,
   input wire logic pd_falling_en_o,
   input wire logic [2:0] loop_bandwidth_scale_o,
   input wire logic [3:0] sample_phase_offset_o,
   input wire logic sample_phase_active_o,
   input wire logic equalizer_path_o,
   input wire logic flat_path_o,
   input wire logic data_squelch_o,
   input wire logic output_driver_off_o,
   input wire logic ddr_clock_off_o,
   input wire logic data_invert_o,
   input wire logic [3:0] output_amplitude_o,
   input wire logic amplitude_code_valid_o
);
   // ---------------------------------------------------------------
   // Port timing and decoded fields
   // ---------------------------------------------------------------
   // Decoded outputs trail the write edge by two edges, so the data
   // byte is looked up two samples back.
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   AST_RD_ANSWER: assert property (ce_i && reg_rd_i |=> reg_rvalid_o)
      else $error("read strobe not answered");
   AST_NO_SPURIOUS: assert property (ce_i && !reg_rd_i |=> !reg_rvalid_o)
      else $error("read answer without a read");
   AST_UNMAPPED_RD: assert property (ce_i && reg_rd_i && !(reg_addr_i inside
      {8'h10, 8'h13, 8'h14, 8'h16, 8'h1e, 8'h1f}) |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   AST_EDGE_SEL: assert property ((ce_i && reg_wr_i && reg_addr_i == 8'h10) ##1 ce_i
      |=> {pd_rising_en_o, pd_falling_en_o} == {$past(reg_wdata_i[4:3], 2) != 2'h2,
      $past(reg_wdata_i[4:3], 2) != 2'h1}) else $error("edge selection wrong");
   AST_BW_SCALE: assert property ((ce_i && reg_wr_i && reg_addr_i == 8'h10) ##1 ce_i
      |=> loop_bandwidth_scale_o == $past(reg_wdata_i[2:0], 2))
      else $error("bandwidth scale wrong");
   AST_PHASE_GATE: assert property (ce_i && !rate_above_threshold_i
      |=> sample_phase_offset_o == 4'h0) else $error("phase offset not gated");
   AST_PHASE_ACTIVE: assert property (ce_i |=>
      sample_phase_active_o == $past(rate_above_threshold_i))
      else $error("phase active flag wrong");
   AST_INPUT_PATH: assert property ((ce_i && reg_wr_i && reg_addr_i == 8'h16) ##1 ce_i
      |=> {equalizer_path_o, flat_path_o} == {$past(reg_wdata_i[6:5], 2) == 2'h1,
      $past(reg_wdata_i[6:5], 2) == 2'h2}) else $error("input path wrong");
   AST_OUT_CTRL: assert property ((ce_i && reg_wr_i && reg_addr_i == 8'h1e) ##1 ce_i
      |=> {data_squelch_o, output_driver_off_o, ddr_clock_off_o, data_invert_o} ==
      {$past(reg_wdata_i[5:4], 2), $past(reg_wdata_i[2:1], 2)})
      else $error("output control wrong");
   AST_AMP_VALID: assert property (amplitude_code_valid_o ==
      (output_amplitude_o >= 4'h4)) else $error("amplitude valid flag wrong");
endmodule

bind cdr_cfg_regs cdr_cfg_regs_checker i_chk (.*);

// ---- bench/cdr_cfg_regs_tb.sv ----
// Self-checking bench for the configuration register bank.
// Assumes the host model drives the register port; the bench drives the rest.
`timescale 1ns/1ps
module cdr_cfg_regs_tb;
   import cdr_cfg_pkg::*;
   logic mclk_i, resetn_i, ce_i, rate_i, wr, rd, rvalid, rise, fall, term, eqp, flat;
   logic autoeq, sq, drv, ddr, inv, act, valid;
   logic [7:0] addr, wdata, rdata;
   logic [2:0] scale;
   logic [1:0] slew;
   logic [3:0] phase, gain, amp;
   int bad_count = 0;
   int comparisons = 0;
   logic [7:0] tbl [3];

   cdr_host_model i_host (.mclk_i(mclk_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
      .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
   cdr_cfg_regs i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .rate_above_threshold_i(rate_i), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .pd_rising_en_o(rise), .pd_falling_en_o(fall), .loop_bandwidth_scale_o(scale),
      .delay_loop_slew_o(slew), .sample_phase_offset_o(phase),
      .sample_phase_active_o(act), .term_float_o(term), .equalizer_path_o(eqp),
      .flat_path_o(flat), .auto_equalize_on_o(autoeq), .equalizer_gain_o(gain),
      .data_squelch_o(sq), .output_driver_off_o(drv), .ddr_clock_off_o(ddr),
      .data_invert_o(inv), .output_amplitude_o(amp), .amplitude_code_valid_o(valid));

   // ---------------------------------------------------------------
   // Clock, watchdog and shared tasks
   // ---------------------------------------------------------------
   initial
   begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end

   // A hang counts as a mismatch and still reaches the verdict.
   initial
   begin
      repeat (20000) @(posedge mclk_i);
      bad_count++;
      finish_test();
   end

   task automatic finish_test();
      if (bad_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      bit ok;
      i_host.read_reg(a, d, ok);
      if (!ok)
      begin
         bad_count++;
         finish_test();
      end
      check(d, exp);
   endtask

   // Decoded outputs settle two edges after the write is taken.
   task automatic wr_out(input logic [7:0] a, input logic [7:0] d, input bit raw);
      i_host.write_reg(a, d, raw);
      repeat (2) @(posedge mclk_i);
      #1;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial
   begin
      resetn_i = 1'b0;
      ce_i = 1'b1;
      rate_i = 1'b0;
      repeat (2) @(posedge mclk_i);
      resetn_i <= 1'b1;
      rd_chk(8'h10, 8'h04);
      rd_chk(8'h13, 8'h00);
      rd_chk(8'h14, 8'h00);
      rd_chk(8'h16, CDR_INPUT_STAGE_RST);
      rd_chk(8'h1e, 8'h08);
      rd_chk(8'h1f, 8'hcc);
      check({4'h0, amp}, 8'h0c);
      for (int e = 0; e < 4; e++)
      begin
         wr_out(8'h10, {3'h0, e[1:0], 3'(e + 1)}, 1'b0);
         check({6'h0, rise, fall}, {6'h0, e != 2, e != 1});
         check({5'h0, scale}, 8'(e + 1));
      end
      wr_out(8'h13, 8'hff, 1'b1);
      check({6'h0, slew}, 8'h03);
      rd_chk(8'h13, 8'h03);
      wr_out(8'h14, 8'h09, 1'b0);
      check({3'h0, act, phase}, 8'h00);
      @(posedge mclk_i);
      rate_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      #1;
      check({3'h0, act, phase}, 8'h19);
      rd_chk(8'h14, 8'h09);
      tbl = '{8'hda, 8'h25, 8'h4f};
      foreach (tbl[i])
      begin
         wr_out(8'h16, tbl[i], 1'b0);
         check({4'h0, term, eqp, flat, autoeq}, {4'h0, tbl[i][7], tbl[i][6:5] == 2'h1,
            tbl[i][6:5] == 2'h2, tbl[i][4]});
         check({4'h0, gain}, {4'h0, tbl[i][3:0]});
         rd_chk(8'h16, tbl[i]);
      end
      tbl = '{8'h3e, 8'h0a, 8'h2c};
      foreach (tbl[i])
      begin
         wr_out(8'h1e, tbl[i], 1'b0);
         check({4'h0, sq, drv, ddr, inv}, {4'h0, tbl[i][5:4], tbl[i][2:1]});
         rd_chk(8'h1e, tbl[i]);
      end
      wr_out(8'h1e, 8'hc1, 1'b1);
      check({4'h0, sq, drv, ddr, inv}, 8'h00);
      rd_chk(8'h1e, 8'h08);
      wr_out(8'h1f, 8'h2c, 1'b1);
      check({3'h0, valid, amp}, 8'h02);
      rd_chk(8'h1f, 8'h2c);
      tbl = '{8'h4c, 8'hfc, 8'hcc};
      foreach (tbl[i])
      begin
         wr_out(8'h1f, tbl[i], 1'b0);
         check({3'h0, valid, amp}, {4'h1, tbl[i][7:4]});
         rd_chk(8'h1f, tbl[i]);
      end
      wr_out(8'h11, 8'h5a, 1'b1);
      rd_chk(8'h11, 8'h00);
      rd_chk(8'h10, 8'h1c);
      @(posedge mclk_i);
      ce_i <= 1'b0;
      i_host.write_reg(8'h1f, 8'h5c, 1'b0);
      ce_i <= 1'b1;
      rd_chk(8'h1f, 8'hcc);
      finish_test();
   end
endmodule

// ---- bench/cdr_host_model.sv ----
// Host on the serial port, reduced to the decoded address and strobe port.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
module cdr_host_model
   import cdr_cfg_pkg::*;
(
   input wire logic mclk_i,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_wr_o,
   output logic reg_rd_o
);
   initial
   begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end

   // A careful host fixes reserved bits and sends no illegal code except amplitude code zero.
   function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
      case (a)
         8'h10: legal = d & 8'h1f;
         8'h13: legal = d & 8'h03;
         8'h14: legal = d & 8'h0f;
         8'h16: legal = (d[6:5] inside {2'h1, 2'h2}) ? d : {d[7], 2'h1, d[4:0]};
         8'h1e: legal = (d & 8'h36) | 8'h08;
         8'h1f: legal = {(d[7:4] inside {4'h1, 4'h2, 4'h3}) ? 4'h4 : d[7:4], 4'hc};
         default: legal = d;
      endcase
   endfunction

   // Released lines show the inverse so a stale value is never reused.
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input bit raw);
      @(posedge mclk_i);
      reg_addr_o <= a;
      reg_wdata_o <= raw ? d : legal(a, d);
      reg_wr_o <= 1'b1;
      @(posedge mclk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask

   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output bit ok);
      ok = 1'b0;
      d = 8'h00;
      @(posedge mclk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge mclk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      for (int i = 0; i < 3 && !ok; i++)
      begin
         #1;
         ok = (reg_rvalid_i === 1'b1);
         d = reg_rdata_i;
         if (!ok) @(posedge mclk_i);
      end
   endtask
endmodule

// ---- rtl/cdr_cfg_pkg.sv ----
// Package for the loop, input-stage and output configuration register bank.
// Assumes the two-wire serial port outside this block decodes each transfer
// into one register address, one data byte and a read or write strobe.
package cdr_cfg_pkg;

   // ----------------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------------
   localparam logic [7:0] CDR_LOOP_EDGE_AND_BANDWIDTH_ADDR = 8'h10;
   localparam logic [7:0] CDR_DELAY_LOOP_SLEW_ADDR = 8'h13;
   localparam logic [7:0] CDR_SAMPLING_PHASE_OFFSET_ADDR = 8'h14;
   localparam logic [7:0] CDR_INPUT_STAGE_CONFIG_ADDR = 8'h16;
   localparam logic [7:0] CDR_OUTPUT_CONTROL_ADDR = 8'h1e;
   localparam logic [7:0] CDR_OUTPUT_AMPLITUDE_ADDR = 8'h1f;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int CDR_BW_SCALE_LSB = 0;     // Bandwidth scale, 3 bits.
   localparam int CDR_EDGE_SEL_LSB = 3;     // Edge selection, 2 bits.
   localparam int CDR_SLEW_LSB = 0;         // Delay-loop slew, 2 bits.
   localparam int CDR_PHASE_LSB = 0;        // Sample phase offset, 4 bits.
   localparam int CDR_GAIN_LSB = 0;         // Equalizer gain, 4 bits.
   localparam int CDR_AUTO_EQ_BIT = 4;      // Adaptive equalizer enable.
   localparam int CDR_INPUT_SEL_LSB = 5;    // Input stage select, 2 bits.
   localparam int CDR_TERM_FLOAT_BIT = 7;   // Termination common-mode float.
   localparam int CDR_POLARITY_BIT = 1;     // Output data polarity flip.
   localparam int CDR_DDR_OFF_BIT = 2;      // Double-rate clock disable.
   localparam int CDR_FIXED_ONE_BIT = 3;    // Reserved bit that reads one.
   localparam int CDR_DRIVER_OFF_BIT = 4;   // Data output driver disable.
   localparam int CDR_SQUELCH_BIT = 5;      // Data squelch.
   localparam int CDR_AMPLITUDE_LSB = 4;    // Output amplitude, 4 bits.

   // ----------------------------------------------------------------------
   // Reset values of the stored fields
   // ----------------------------------------------------------------------
   localparam logic [2:0] CDR_BW_SCALE_RST = 3'h4;
   localparam logic [1:0] CDR_EDGE_SEL_RST = 2'h0;
   localparam logic [1:0] CDR_SLEW_RST = 2'h0;
   localparam logic [3:0] CDR_PHASE_RST = 4'h0;
   localparam logic [7:0] CDR_INPUT_STAGE_RST = 8'h20;
   localparam logic [3:0] CDR_OUTPUT_CTRL_RST = 4'h0;
   localparam logic [3:0] CDR_AMPLITUDE_RST = 4'hc;

   // ----------------------------------------------------------------------
   // Codes and fixed read values
   // ----------------------------------------------------------------------
   localparam logic [1:0] CDR_EDGE_RISING_ONLY = 2'h1;
   localparam logic [1:0] CDR_EDGE_FALLING_ONLY = 2'h2;
   localparam logic [1:0] CDR_INPUT_EQUALIZER = 2'h1;
   localparam logic [1:0] CDR_INPUT_FLAT = 2'h2;
   localparam logic [3:0] CDR_AMPLITUDE_MIN_VALID = 4'h4;
   localparam logic [3:0] CDR_AMPLITUDE_LOW_NIBBLE = 4'hc;
   localparam logic [7:0] CDR_UNMAPPED_READ = 8'h00;

endpackage

// ---- rtl/cdr_cfg_regs.sv ----
// Configuration register bank for the data recovery loop, input stage and
// output driver. Assumes the serial port decoder outside presents single-
// cycle read and write strobes with an address and data byte on mclk_i.
`timescale 1ns/1ps

module cdr_cfg_regs
   import cdr_cfg_pkg::*;
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic rate_above_threshold_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   output logic pd_rising_en_o,
   output logic pd_falling_en_o,
   output logic [2:0] loop_bandwidth_scale_o,
   output logic [1:0] delay_loop_slew_o,
   output logic [3:0] sample_phase_offset_o,
   output logic sample_phase_active_o,
   output logic term_float_o,
   output logic equalizer_path_o,
   output logic flat_path_o,
   output logic auto_equalize_on_o,
   output logic [3:0] equalizer_gain_o,
   output logic data_squelch_o,
   output logic output_driver_off_o,
   output logic ddr_clock_off_o,
   output logic data_invert_o,
   output logic [3:0] output_amplitude_o,
   output logic amplitude_code_valid_o
);

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   // Each register has its own write strobe. Writes to any other address
   // fall through without effect, so the decoder never stalls the host.
   logic wr_loop; // Write to the loop edge and bandwidth register.
   logic wr_slew; // Write to the delay-loop slew register.
   logic wr_phase; // Write to the sampling phase offset register.
   logic wr_input; // Write to the input stage register.
   logic wr_outctl; // Write to the output control register.
   logic wr_amp; // Write to the output amplitude register.

   assign wr_loop = reg_wr_i && (reg_addr_i == CDR_LOOP_EDGE_AND_BANDWIDTH_ADDR);
   assign wr_slew = reg_wr_i && (reg_addr_i == CDR_DELAY_LOOP_SLEW_ADDR);
   assign wr_phase = reg_wr_i && (reg_addr_i == CDR_SAMPLING_PHASE_OFFSET_ADDR);
   assign wr_input = reg_wr_i && (reg_addr_i == CDR_INPUT_STAGE_CONFIG_ADDR);
   assign wr_outctl = reg_wr_i && (reg_addr_i == CDR_OUTPUT_CONTROL_ADDR);
   assign wr_amp = reg_wr_i && (reg_addr_i == CDR_OUTPUT_AMPLITUDE_ADDR);

   // ----------------------------------------------------------------------
   // Stored fields
   // ----------------------------------------------------------------------
   // Only the defined fields are stored. Reserved bits of a write are
   // dropped here, which keeps a careless host from disturbing the loop.
   logic [2:0] bw_scale; // Loop bandwidth scale.
   logic [1:0] edge_sel; // Phase-detector edge selection.
   logic [1:0] slew; // Delay-loop slew.
   logic [3:0] phase; // Signed sample phase offset.
   logic [7:0] input_stage; // Whole input stage register, all bits defined.
   logic [3:0] out_ctl; // Squelch, driver off, double-rate off, polarity.
   logic [3:0] amplitude; // Output amplitude code.

   // Bandwidth scale comes up at four, the nominal loop bandwidth.
   cdr_field_reg #(.WIDTH(3), .RESET_VALUE(CDR_BW_SCALE_RST)) u_bw_scale
   (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .wr_i(wr_loop),
      .wdata_i(reg_wdata_i[CDR_BW_SCALE_LSB +: 3]),
      .value_o(bw_scale)
   );

   // Edge selection sits above the bandwidth scale in the same register.
   cdr_field_reg #(.WIDTH(2), .RESET_VALUE(CDR_EDGE_SEL_RST)) u_edge_sel
   (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .wr_i(wr_loop),
      .wdata_i(reg_wdata_i[CDR_EDGE_SEL_LSB +: 2]),
      .value_o(edge_sel)
   );

   // Only the low two bits are kept; the upper six read back as zero.
   cdr_field_reg #(.WIDTH(2), .RESET_VALUE(CDR_SLEW_RST)) u_slew
   (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .wr_i(wr_slew),
      .wdata_i(reg_wdata_i[CDR_SLEW_LSB +: 2]),
      .value_o(slew)
   );

   // The phase nibble is stored raw and treated as signed further on.
   cdr_field_reg #(.WIDTH(4), .RESET_VALUE(CDR_PHASE_RST)) u_phase
   (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .wr_i(wr_phase),
      .wdata_i(reg_wdata_i[CDR_PHASE_LSB +: 4]),
      .value_o(phase)
   );

   // Every bit of the input stage register carries a field.
   cdr_field_reg #(.WIDTH(8), .RESET_VALUE(CDR_INPUT_STAGE_RST)) u_input_stage
   (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .wr_i(wr_input),
      .wdata_i(reg_wdata_i),
      .value_o(input_stage)
   );

   // Output control keeps bits five to one; bit three is fixed and ignored.
   cdr_field_reg #(.WIDTH(4), .RESET_VALUE(CDR_OUTPUT_CTRL_RST)) u_out_ctl
   (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .wr_i(wr_outctl),
      .wdata_i({reg_wdata_i[CDR_SQUELCH_BIT], reg_wdata_i[CDR_DRIVER_OFF_BIT],
                reg_wdata_i[CDR_DDR_OFF_BIT], reg_wdata_i[CDR_POLARITY_BIT]}),
      .value_o(out_ctl)
   );

   // Amplitude comes up at code twelve, a mid-high swing.
   cdr_field_reg #(.WIDTH(4), .RESET_VALUE(CDR_AMPLITUDE_RST)) u_amplitude
   (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .wr_i(wr_amp),
      .wdata_i(reg_wdata_i[CDR_AMPLITUDE_LSB +: 4]),
      .value_o(amplitude)
   );

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   // Read data is registered so the serial shifter sees a stable byte one
   // cycle after the strobe. Unmapped addresses answer with zero.
   logic [7:0] rdata_q; // Registered read byte.
   logic [7:0] rdata_d; // Next read byte.
   logic rvalid_q; // Read answer pulse.
   logic rvalid_d; // Next read answer pulse.
   logic [7:0] rmux; // Byte selected by the address.

   // Reserved bits read as their fixed values, not as what was written.
   always_comb
   begin
      rmux = CDR_UNMAPPED_READ;
      case (reg_addr_i)
         CDR_LOOP_EDGE_AND_BANDWIDTH_ADDR: rmux = {3'h0, edge_sel, bw_scale};
         CDR_DELAY_LOOP_SLEW_ADDR: rmux = {6'h00, slew};
         CDR_SAMPLING_PHASE_OFFSET_ADDR: rmux = {4'h0, phase};
         CDR_INPUT_STAGE_CONFIG_ADDR: rmux = input_stage;
         CDR_OUTPUT_CONTROL_ADDR: rmux = {2'h0, out_ctl[3], out_ctl[2], 1'b1,
                                          out_ctl[1], out_ctl[0], 1'b0};
         CDR_OUTPUT_AMPLITUDE_ADDR: rmux = {amplitude, CDR_AMPLITUDE_LOW_NIBBLE};
         default: rmux = CDR_UNMAPPED_READ;
      endcase
   end

   // The answer byte holds until the next read; the valid flag follows the read strobe while ce_i is high and holds while it is low.
   always_comb
   begin
      rdata_d = rdata_q;
      rvalid_d = rvalid_q;
      if (ce_i)
      begin
         rvalid_d = reg_rd_i;
         if (reg_rd_i)
         begin
            rdata_d = rmux;
         end
      end
   end

   // Registers for the read answer.
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // ----------------------------------------------------------------------
   // Decoded controls for the analog and loop circuits
   // ----------------------------------------------------------------------
   // All controls are re-registered so each output comes from a flop. This
   // costs one cycle of lag after a write, which the slow loops never see.
   logic [28:0] ctl_q; // Registered control outputs, packed, amplitude included.
   logic [28:0] ctl_d; // Next control outputs.
   logic rise_en; // Rising transitions feed the phase detector.
   logic fall_en; // Falling transitions feed the phase detector.
   logic phase_active; // Sample phase offset is in force.
   logic [3:0] phase_applied; // Offset handed to the sampler.
   logic eq_path; // Equalizer input stage chosen.
   logic flat_path; // Flat zero-gain input stage chosen.
   logic amp_valid; // Amplitude code is in the usable range.

   // Edge selection: codes 00 and 11 both mean both edges, so each enable
   // drops only for the one code that names the other edge alone.
   always_comb
   begin
      rise_en = (edge_sel != CDR_EDGE_FALLING_ONLY);
      fall_en = (edge_sel != CDR_EDGE_RISING_ONLY);
   end

   // The signed offset, one count per 1/32 UI, is only passed on while the
   // recovered rate is above 5.65 Gbps; below that the sampler sees zero.
   always_comb
   begin
      phase_active = rate_above_threshold_i;
      phase_applied = phase_active ? phase : 4'h0;
   end

   // Undefined input select codes enable neither path, so nothing is driven
   // by a half-decoded setting.
   always_comb
   begin
      eq_path = (input_stage[CDR_INPUT_SEL_LSB +: 2] == CDR_INPUT_EQUALIZER);
      flat_path = (input_stage[CDR_INPUT_SEL_LSB +: 2] == CDR_INPUT_FLAT);
   end

   // Codes zero to three are flagged; the driver should hold its swing.
   always_comb
   begin
      amp_valid = (amplitude >= CDR_AMPLITUDE_MIN_VALID);
   end

   // Packing of all decoded controls into one next-state word.
   always_comb
   begin
      ctl_d = ctl_q;
      if (ce_i)
      begin
         ctl_d = {rise_en, fall_en,
                  bw_scale,
                  slew,
                  phase_applied, phase_active,
                  input_stage[CDR_TERM_FLOAT_BIT],
                  eq_path, flat_path,
                  input_stage[CDR_AUTO_EQ_BIT],
                  input_stage[CDR_GAIN_LSB +: 4],
                  out_ctl[3], out_ctl[2],
                  out_ctl[1],
                  out_ctl[0],
                  amplitude,
                  amp_valid};
      end
   end

   // The reset value mirrors the reset values of the stored fields.
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ctl_q <= {2'b11, CDR_BW_SCALE_RST, CDR_SLEW_RST, 4'h0, 1'b0,
                   CDR_INPUT_STAGE_RST[7], 1'b1, 1'b0, CDR_INPUT_STAGE_RST[4],
                   CDR_INPUT_STAGE_RST[3:0], CDR_OUTPUT_CTRL_RST, CDR_AMPLITUDE_RST, 1'b1};
      end
      else
      begin
         ctl_q <= ctl_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign reg_rdata_o = rdata_q;
   assign reg_rvalid_o = rvalid_q;
   assign pd_rising_en_o = ctl_q[28];
   assign pd_falling_en_o = ctl_q[27];
   // The scale reads as a fixed-point gain with two fraction bits, so the
   // bandwidth consumer multiplies the nominal figure by scale over four.
   assign loop_bandwidth_scale_o = ctl_q[26:24];
   assign delay_loop_slew_o = ctl_q[23:22];
   assign sample_phase_offset_o = ctl_q[21:18];
   assign sample_phase_active_o = ctl_q[17];
   assign term_float_o = ctl_q[16];
   assign equalizer_path_o = ctl_q[15];
   assign flat_path_o = ctl_q[14];
   // Manual gain is still presented while adapting; the equalizer ignores it.
   assign auto_equalize_on_o = ctl_q[13];
   assign equalizer_gain_o = ctl_q[12:9];
   assign data_squelch_o = ctl_q[8];
   assign output_driver_off_o = ctl_q[7];
   assign ddr_clock_off_o = ctl_q[6];
   assign data_invert_o = ctl_q[5];
   // Code and valid flag share one flop word, so they never disagree.
   assign output_amplitude_o = ctl_q[4:1];
   assign amplitude_code_valid_o = ctl_q[0];

endmodule

// ---- rtl/cdr_field_reg.sv ----
// One stored register field with its own reset value and write strobe.
// Assumes writes arrive as single-cycle strobes synchronous to mclk_i.
`timescale 1ns/1ps
module cdr_field_reg
   import cdr_cfg_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic wr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   output logic [WIDTH-1:0] value_o
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   logic [WIDTH-1:0] value_q; // Held field value.
   logic [WIDTH-1:0] value_d; // Next field value.

   // The field only loads on a write strobe while the clock enable is high.
   always_comb
   begin
      value_d = value_q;
      if (ce_i && wr_i)
      begin
         value_d = wdata_i;
      end
   end

   // The reset value is a constant, so no port reaches the reset branch.
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         value_q <= RESET_VALUE;
      end
      else
      begin
         value_q <= value_d;
      end
   end

   assign value_o = value_q;

endmodule
